//--- logic/sdop_port.sv
// serial data output port: spi and frame-sync read-out of conversion words
`timescale 1ns/1ns
`default_nettype none
module sdop_port #(
  parameter int NCH  = sdop_pkg::NUM_CHANNELS,
  parameter int WORD = sdop_pkg::WORD_BITS
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [2:0]            format_select,
  input  wire logic [1:0]            mode_select,
  input  wire logic                  clock_divide_select,
  input  wire logic [NCH-1:0]        channel_power_down_n,
  input  wire logic                  sclk,
  input  wire logic                  frame_sync_in,
  input  wire logic                  chain_in,
  input  wire logic [NCH*WORD-1:0]   conv_data,
  input  wire logic                  conv_valid,
  output var  logic                  conv_ready,
  output var  logic                  data_ready_n,
  output var  logic                  first_serial_out,
  output var  logic [NCH-1:1]        channel_serial_out,
  output var  logic                  frame_period_bad
);
  import sdop_pkg::*;
  localparam int TOT = NCH * WORD;
  localparam int NP  = NCH + 3;
  // idle pin levels: channels up, sclk, frame sync and chain low
  localparam logic [NP-1:0] PIN_IDLE = {{NCH{1'b1}}, 3'b000};

  if (NCH < 2 || WORD < 2) begin : g_bad_cfg
    $error("need at least two channels and two bits per word");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [NP-1:0] s1, s2, s3, st, next_st;
  logic [NCH-1:0] pd_prev, ch_down;
  logic sclk_fall, fs_rise, din_s, all_down;

  // three stages; a change counts once stages two and three agree
  // reset to idle levels so no false power-down or edge follows reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1 <= PIN_IDLE;
      s2 <= PIN_IDLE;
      s3 <= PIN_IDLE;
      st <= PIN_IDLE;
    end else begin
      s1 <= {channel_power_down_n, chain_in, frame_sync_in, sclk};
      s2 <= s1;
      s3 <= s2;
      st <= next_st;
    end
  end

  always_comb begin
    for (int i = 0; i < NP; i++) begin
      next_st[i] = (s2[i] == s3[i]) ? s3[i] : st[i];
    end
  end

  assign sclk_fall = st[0] & ~next_st[0];
  assign fs_rise   = ~st[1] & next_st[1];
  assign din_s     = st[2];

  // power-down after two low clocks, up as soon as high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pd_prev <= '1;
      ch_down <= '0;
    end else begin
      pd_prev <= st[NP-1:3];
      ch_down <= ~st[NP-1:3] & ~pd_prev;
    end
  end

  assign all_down = &ch_down;

  // ----------------------------------------
  // format decode
  // ----------------------------------------
  logic is_fs, is_disc, is_dyn;

  always_comb begin
    is_fs   = 1'b0;
    is_disc = 1'b0;
    is_dyn  = 1'b0;
    case (format_select)
      FMT_SPI_TDM_DYN: is_dyn = 1'b1;
      FMT_SPI_TDM_FIX: is_dyn = 1'b0;
      FMT_SPI_DISC:    is_disc = 1'b1;
      FMT_FS_TDM_DYN:  begin
        is_fs  = 1'b1;
        is_dyn = 1'b1;
      end
      FMT_FS_TDM_FIX:  is_fs = 1'b1;
      default:         begin
        is_fs   = 1'b1;
        is_disc = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // conversion word buffer
  // ----------------------------------------
  logic [TOT-1:0] buf_data;
  logic           buf_valid, buf_take;

  sdop_pair_buffer #(.WIDTH(TOT), .DEPTH(BUF_DEPTH)) u_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (conv_data),
    .in_valid  (conv_valid),
    .in_ready  (conv_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_take)
  );

  // ----------------------------------------
  // frame assembly
  // ----------------------------------------
  logic [TOT-1:0] frame;

  // zero or remove powered-down channel slots, channel 1 in the top slot
  always_comb begin
    int k;
    k     = 0;
    frame = '0;
    for (int c = 0; c < NCH; c++) begin
      if (!ch_down[c]) begin
        if (is_dyn && !is_disc) begin
          frame[TOT-1-WORD*k -: WORD] = buf_data[TOT-1-WORD*c -: WORD];
        end else begin
          frame[TOT-1-WORD*c -: WORD] = buf_data[TOT-1-WORD*c -: WORD];
        end
        k = k + 1;
      end
    end
  end

  // ----------------------------------------
  // load control and data_ready_n
  // ----------------------------------------
  sdop_state_t state;
  logic        load;

  // spi loads when high or after the warning pulse, frame-sync on frame start
  always_comb begin
    if (all_down) load = 1'b0;
    else if (is_fs) load = fs_rise;
    else load = buf_valid && (data_ready_n || state == st_pulse);
  end

  assign buf_take = load & buf_valid;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state        <= st_idle;
      data_ready_n <= 1'b1;
    end else if (is_fs || all_down) begin
      state        <= st_idle;
      data_ready_n <= 1'b1;
    end else begin
      case (state)
        st_idle: begin
          if (load) begin
            data_ready_n <= 1'b0;
          end else if (buf_valid && !data_ready_n) begin
            data_ready_n <= 1'b1;
            state        <= st_pulse;
          end else if (sclk_fall) begin
            data_ready_n <= 1'b1;
          end
        end
        default: begin
          data_ready_n <= 1'b0;
          state        <= st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------
  // shift register and outputs
  // ----------------------------------------
  logic [TOT-1:0] sr, next_sr;
  logic [NCH-1:0] dout, next_dout;

  always_comb begin
    next_sr = sr;
    if (all_down) begin
      next_sr = '0;
    end else if (load) begin
      next_sr = buf_take ? frame : '0;
    end else if (sclk_fall) begin
      if (is_disc) begin
        for (int c = 0; c < NCH; c++) begin
          next_sr[TOT-1-WORD*c -: WORD] = {sr[TOT-2-WORD*c -: WORD-1], 1'b0};
        end
      end else begin
        next_sr = {sr[TOT-2:0], din_s};
      end
    end
  end

  // tdm on the first pin only, discrete on every pin
  always_comb begin
    next_dout = '0;
    if (!all_down) begin
      if (is_disc) begin
        for (int c = 0; c < NCH; c++) begin
          next_dout[c] = next_sr[TOT-1-WORD*c] & ~ch_down[c];
        end
      end else begin
        next_dout[0] = next_sr[TOT-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sr   <= '0;
      dout <= '0;
    end else begin
      sr   <= next_sr;
      dout <= next_dout;
    end
  end

  assign first_serial_out   = dout[0];
  assign channel_serial_out = dout[NCH-1:1];

  // ----------------------------------------
  // frame period check
  // ----------------------------------------
  logic [FRAME_CNT_W-1:0] frame_cnt, expected;
  logic                   seen_frame;

  always_comb begin
    case (mode_select)
      MODE_HIGH_SPEED: expected = CYC_HS;
      MODE_HIGH_RES:   expected = CYC_HR;
      MODE_LOW_POWER:  expected = clock_divide_select ? CYC_LP_DIV1 : CYC_LP_DIV0;
      default:         expected = clock_divide_select ? CYC_LS_DIV1 : CYC_LS_DIV0;
    endcase
  end

  // flags each frame whose length differs from the conversion period
  always_ff @(posedge clk) begin
    if (sys_rst || !is_fs) begin
      frame_cnt        <= '0;
      seen_frame       <= 1'b0;
      frame_period_bad <= 1'b0;
    end else if (fs_rise) begin
      frame_cnt        <= 12'h001;
      seen_frame       <= 1'b1;
      frame_period_bad <= seen_frame && (frame_cnt != expected);
    end else if (frame_cnt != '1) begin
      frame_cnt <= frame_cnt + 12'h001;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_low_twice(int c);
    !st[3+c] ##1 !st[3+c];
  endsequence

  sequence s_warn_then_load;
    data_ready_n ##1 !data_ready_n;
  endsequence

  chk_channel_power_down_n_filter: assert property (s_low_twice(0) |=> ch_down[0])
    else $error("channel 1 not down after two low clocks");
  chk_channel_power_down_n_release: assert property (st[3] |=> !ch_down[0])
    else $error("channel 1 stays down after input high");
  chk_data_ready_n_warn: assert property (!is_fs && !all_down && !data_ready_n && buf_valid
      && state == st_idle ##1 !is_fs && !all_down |-> s_warn_then_load)
    else $error("unread data not flagged by a high pulse");
  chk_data_ready_n_rise_sclk: assert property (!is_fs && !all_down && state == st_idle && !load
      && !data_ready_n && !buf_valid && sclk_fall |=> data_ready_n)
    else $error("data_ready_n not released by falling sclk");
  chk_data_ready_n_msb: assert property (!is_fs && !is_disc && !is_dyn && !ch_down[0]
      && load && buf_valid |=> !data_ready_n && first_serial_out == $past(buf_data[TOT-1]))
    else $error("msb missing when data_ready_n falls");
  chk_fs_load: assert property (is_fs && !is_disc && !is_dyn && !ch_down[0] && fs_rise
      && buf_valid |-> buf_take ##1 first_serial_out == $past(buf_data[TOT-1]))
    else $error("frame start did not take new data");
  chk_chain_fwd: assert property (!is_disc && !all_down && !load && sclk_fall
      |=> sr[0] == $past(din_s))
    else $error("chain input not forwarded");
  chk_disc_zero: assert property (is_disc ##1 is_disc |-> (dout & $past(ch_down)) == '0)
    else $error("powered-down discrete channel not zero");
  chk_all_down_quiet: assert property (all_down |=> dout == '0 && data_ready_n)
    else $error("outputs active with every channel down");
  chk_disc_shift: assert property (is_disc && !all_down && !load && sclk_fall
      |=> sr[TOT-1 -: WORD] == {$past(sr[TOT-2 -: WORD-1]), 1'b0})
    else $error("discrete word did not shift in zero");
endmodule : sdop_port
`default_nettype wire

//--- logic/sdop_pkg.sv
// constants and rule summary for the converter serial data output port
// Operation
// - spi protocol is read-only, data_ready_n low flags data, msb first on falling sclk
// - chain input sampled on falling sclk while output shifts on falling sclk
// - data_ready_n falls on new data, rises on first following falling sclk
// - unread data: data_ready_n pulses high, new data loaded one clock before fall; the code loads on the same clock edge as the fall
// - msb present once data_ready_n low, next bit after each falling sclk
// - frame-sync: msb valid after frame sync rises, later bits per falling sclk
// - discrete mode one pin per channel, tdm mode all on first output
// - tdm: channel 1 first, ascending, then forward chain input bits
// - all channels down disables outputs and chain forwarding
// - fixed tdm keeps slots, powered-down channel slot is zero
// - dynamic tdm removes powered-down slots, higher channels move earlier
// - discrete: parallel words, zero after 24th sclk, down channels zero
// - format select codes choose protocol and data mode
// - master clocks per conversion set by mode and clock divide select
// - channel powers down after its input low two clocks, up when high
package sdop_pkg;
  // ----------------------------------------
  // format select codes
  // ----------------------------------------
  localparam logic [2:0] FMT_SPI_TDM_DYN = 3'h0;
  localparam logic [2:0] FMT_SPI_TDM_FIX = 3'h1;
  localparam logic [2:0] FMT_SPI_DISC    = 3'h2;
  localparam logic [2:0] FMT_FS_TDM_DYN  = 3'h3;
  localparam logic [2:0] FMT_FS_TDM_FIX  = 3'h4;
  localparam logic [2:0] FMT_FS_DISC     = 3'h5;
  // ----------------------------------------
  // operating mode codes
  // ----------------------------------------
  localparam logic [1:0] MODE_HIGH_SPEED = 2'h0;
  localparam logic [1:0] MODE_HIGH_RES   = 2'h1;
  localparam logic [1:0] MODE_LOW_POWER  = 2'h2;
  localparam logic [1:0] MODE_LOW_SPEED  = 2'h3;
  // ----------------------------------------
  // master clocks per conversion
  // ----------------------------------------
  localparam int          FRAME_CNT_W   = 12;
  localparam logic [11:0] CYC_HS        = 12'h100;
  localparam logic [11:0] CYC_HR        = 12'h200;
  localparam logic [11:0] CYC_LP_DIV1   = 12'h200;
  localparam logic [11:0] CYC_LP_DIV0   = 12'h100;
  localparam logic [11:0] CYC_LS_DIV1   = 12'hA00;
  localparam logic [11:0] CYC_LS_DIV0   = 12'h200;
  // ----------------------------------------
  // widths and timing
  // ----------------------------------------
  localparam int WORD_BITS      = 24;
  localparam int NUM_CHANNELS   = 8;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CHANNEL_POWER_DOWN_N_MIN_CLKS  = 2;
  localparam int SYNC_STAGES    = 3;
  localparam int BUF_DEPTH      = 2;
  // spi handshake states
  typedef enum logic [0:0] {st_idle, st_pulse} sdop_state_t;
endpackage : sdop_pkg

//--- logic/sdop_pair_buffer.sv
// small word buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sdop_pair_buffer #(
  parameter int WIDTH = 192,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  import sdop_pkg::*;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("depth must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic [PW:0]      next_count;
  logic             push;
  logic             pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // occupancy and registered ready
  always_comb begin
    next_count = count;
    if (push && !pop) next_count = count + 1'b1;
    else if (pop && !push) next_count = count - 1'b1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count    <= '0;
      in_ready <= 1'b1;
    end else begin
      count    <= next_count;
      in_ready <= (next_count < (PW+1)'(DEPTH));
    end
  end

  // storage and pointers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : sdop_pair_buffer
`default_nettype wire

//--- tb/sdop_host_model.sv
// host model: drives sclk, frame sync and chain input, captures the data outputs
`timescale 1ns/1ns
`default_nettype none
module sdop_host_model #(
  parameter int NCH = 8,
  parameter int H   = 4
) (
  input  wire logic           clk,
  input  wire logic           first_serial_out,
  input  wire logic [NCH-1:1] channel_serial_out,
  output var  logic           sclk,
  output var  logic           frame_sync_in,
  output var  logic           chain_in
);
  logic [255:0]         cap_first;
  logic [NCH-1:1][31:0] cap_ch;
  logic [31:0]          chain_word;
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  initial begin
    sclk = 1'b0;
    frame_sync_in = 1'b0;
    chain_in = 1'b0;
    chain_word = '0;
  end
  // ----------------------------------------
  // bit clocking
  // ----------------------------------------
  // sclk at clk/8; in frame mode one call is one frame of n sclk periods
  task automatic clock_bits(input int n, input bit fs);
    cap_first = '0;
    cap_ch = '0;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < H; k++) begin
        if (fs && k == 2) frame_sync_in = (i < n / 2);
        @(negedge clk);
      end
      // first rise comes H clocks after the call, so after ready falls
      sclk = 1'b1;
      // upstream word changes mid-bit, well clear of the falling edge
      chain_in = (i < 32) ? chain_word[31-i] : 1'b0;
      for (int k = 0; k < H; k++) @(negedge clk);
      // late capture covers the device's input synchroniser delay
      if (i < 256) cap_first[255-i] = first_serial_out;
      if (i < 32) for (int c = 1; c < NCH; c++) cap_ch[c][31-i] = channel_serial_out[c];
      sclk = 1'b0;
    end
  endtask : clock_bits
endmodule : sdop_host_model
`default_nettype wire

//--- tb/tb_adc_serial_data_output_port.sv
// self-checking bench for the serial data output port
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end
module tb_adc_serial_data_output_port;
  import sdop_pkg::*;
  logic           clk, sys_rst, clock_divide_select, conv_valid, conv_ready;
  logic           data_ready_n, first_serial_out, frame_period_bad;
  logic           sclk, frame_sync_in, chain_in;
  logic [2:0]     format_select;
  logic [1:0]     mode_select;
  logic [7:0]     channel_power_down_n;
  logic [7:1]     channel_serial_out;
  logic [191:0]   conv_data, set_a;
  int             mismatches, n_checks;

  sdop_port dut (.clk, .sys_rst, .format_select, .mode_select, .clock_divide_select,
    .channel_power_down_n, .sclk, .frame_sync_in, .chain_in, .conv_data, .conv_valid,
    .conv_ready, .data_ready_n, .first_serial_out, .channel_serial_out, .frame_period_bad);
  sdop_host_model #(.NCH(8), .H(4)) host (.clk, .first_serial_out, .channel_serial_out,
    .sclk, .frame_sync_in, .chain_in);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [23:0] word(input int c);
    return 24'(32'hC00000 + c * 32'h010203);
  endfunction : word
  // expected first output stream, chain word after eight slots
  function automatic logic [255:0] exp_first(input logic [2:0] f, input logic [7:0] up,
                                             input logic [31:0] cw);
    logic [255:0] e;
    int           p;
    e = '0;
    p = 0;
    if (f == FMT_SPI_DISC || f == FMT_FS_DISC) begin
      if (up[0]) e[255 -: 24] = word(1);
      return e;
    end
    for (int c = 1; c <= 8; c++) begin
      if (up[c-1]) e[255 - 24*p -: 24] = word(c);
      if (up[c-1] || f == FMT_SPI_TDM_FIX || f == FMT_FS_TDM_FIX) p++;
    end
    e[63 -: 32] = cw;
    return e;
  endfunction : exp_first
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // reset with the strap and power-down pins settled, idle values checked at release
  task automatic do_reset(input logic [2:0] f, input logic [7:0] up);
    @(negedge clk);
    sys_rst = 1'b1;
    format_select = f;
    channel_power_down_n = up;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    `CHK({data_ready_n, conv_ready, first_serial_out, frame_period_bad}, 4'b1100)
    repeat (10) @(negedge clk);
  endtask : do_reset
  // three good frames then a half frame, judged against the mode's period
  task automatic check_period(input logic [1:0] m, input logic d, input int bits);
    mode_select = m;
    clock_divide_select = d;
    repeat (3) host.clock_bits(bits, 1'b1);
    `CHK(frame_period_bad, 1'b0)
    host.clock_bits(bits / 2, 1'b1);
    host.clock_bits(bits, 1'b1);
    `CHK(frame_period_bad, 1'b1)
  endtask : check_period
  task automatic wait_data_ready_n(input logic v);
    int k;
    for (k = 0; k < 100 && data_ready_n !== v; k++) @(negedge clk);
    if (k == 100) begin
      mismatches++;
      print_verdict();
    end
  endtask : wait_data_ready_n
  task automatic push(input logic [191:0] d);
    int k;
    @(negedge clk);
    conv_data = d;
    conv_valid = 1'b1;
    for (k = 0; k < 50 && conv_ready !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    conv_valid = 1'b0;
    if (k == 50) begin
      mismatches++;
      print_verdict();
    end
  endtask : push
  // one conversion set read out in the given format and power-down mask
  task automatic run_case(input logic [2:0] f, input logic [7:0] up);
    logic [31:0]  cw;
    logic [255:0] e;
    bit           disc;
    disc = (f == FMT_SPI_DISC || f == FMT_FS_DISC);
    cw = (up == 8'hFF && !disc) ? 32'hF0C3A55A : 32'h0;
    e = exp_first(f, up, cw);
    do_reset(f, up);
    host.chain_word = cw;
    push(set_a);
    if (f >= FMT_FS_TDM_DYN) begin
      host.clock_bits(320, 1'b1);
      `CHK(data_ready_n, 1'b1)
    end else begin
      wait_data_ready_n(1'b0);
      `CHK(first_serial_out, e[255])
      host.clock_bits(224, 1'b0);
      `CHK(data_ready_n, 1'b1)
    end
    `CHK(host.cap_first, e)
    for (int c = 1; c < 8; c++) begin
      `CHK(host.cap_ch[c], (disc && up[c]) ? {word(c + 1), 8'h00} : 32'h0)
    end
    $display("case format %0d mask %h done", f, up);
  endtask : run_case
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    format_select = 3'h0;
    mode_select = MODE_LOW_SPEED;
    clock_divide_select = 1'b1;
    channel_power_down_n = 8'hFF;
    conv_data = '0;
    conv_valid = 1'b0;
    mismatches = 0;
    n_checks = 0;
    for (int c = 1; c <= 8; c++) set_a[191 - 24*(c-1) -: 24] = word(c);
    // every format code, all channels up and channels 1 and 3 down
    for (int f = 0; f < 6; f++) begin
      run_case(3'(f), 8'hFF);
      run_case(3'(f), 8'hFA);
    end
    // all channels down: buffer fills, nothing shifts, chain blocked
    do_reset(FMT_SPI_TDM_FIX, 8'h00);
    host.chain_word = 32'hFFFFFFFF;
    push(set_a);
    push(~set_a);
    repeat (2) @(negedge clk);
    `CHK(conv_ready, 1'b0)
    host.clock_bits(224, 1'b0);
    `CHK({data_ready_n, host.cap_first}, {1'b1, 256'h0})
    channel_power_down_n = 8'hFF;
    wait_data_ready_n(1'b0);
    `CHK({first_serial_out, conv_ready}, 2'b11)
    wait_data_ready_n(1'b1);
    @(negedge clk);
    `CHK({data_ready_n, first_serial_out}, 2'b00)
    $display("buffer fill and drain done");
    // frame period judged for every mode, both divide settings in low speed and low power, eight clocks per bit
    do_reset(FMT_FS_TDM_FIX, 8'hFF);
    host.chain_word = '0;
    check_period(MODE_LOW_SPEED, 1'b1, 320);
    check_period(MODE_LOW_SPEED, 1'b0, 64);
    check_period(MODE_HIGH_SPEED, 1'b1, 32);
    check_period(MODE_HIGH_RES, 1'b1, 64);
    check_period(MODE_LOW_POWER, 1'b1, 64);
    check_period(MODE_LOW_POWER, 1'b0, 32);
    $display("frame period done");
    print_verdict();
  end
endmodule : tb_adc_serial_data_output_port
`undef CHK
`default_nettype wire
